// ===== rvec_core_model.sv
// Behavioural core: runs main code, enters a handler on a vector load, returns.
// Assumes loads of 0x001..0x003 start handlers; other loads resume main code.
`timescale 1ns/1ps
module rvec_core_model (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic load_i,
  input wire logic [8:0] addr_i,
  input wire logic slow_i,
  output logic ready_o,
  output logic ret_o,
  output logic [8:0] pc_o
);
  logic h_q;
  logic t_q;
  logic [1:0] n_q;
  assign ready_o = !hold_i && !rst_i && (!slow_i || t_q);
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      h_q <= 1'b0;
      t_q <= 1'b0;
      n_q <= 2'h0;
      ret_o <= 1'b0;
      pc_o <= 9'h000;
    end else begin
      ret_o <= 1'b0;
      t_q <= !t_q;
      if (load_i) begin
        pc_o <= (addr_i == 9'h000) ? 9'h100 : addr_i;
        h_q <= addr_i != 9'h000 && addr_i < 9'h004;
        n_q <= 2'h0;
      end else if (ready_o) begin
        pc_o <= {pc_o[8], pc_o[7:0] + 8'h01};
      end
      if (h_q && !hold_i && !load_i) begin
        n_q <= n_q + 2'h1;
      end
      if (h_q && n_q == 2'h3) begin
        ret_o <= 1'b1;
        h_q <= 1'b0;
      end
    end
  end
endmodule

// ===== rvec_ctrl.sv
// Reset sequencer and interrupt vectoring unit for a small 8-bit core.
// Assumes rstn_i is the power-on reset; core_ready_i marks instruction boundaries.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module rvec_ctrl #(
  parameter int unsigned TOUT_CYCLES = rvec_pkg::TOUT_CYC,
  parameter int unsigned POR_CYCLES = rvec_pkg::POR_CYC
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic reset_pin_n_i,
  input wire logic ext_request_line_zero_n_i,
  input wire logic timer_wrap_event_i,
  input wire logic comparator_event_i,
  input wire logic wdt_expire_i,
  input wire logic core_ready_i,
  input wire logic return_from_handler_i,
  input wire logic [rvec_pkg::PC_W-1:0] core_pc_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic core_rst_o,
  output logic core_hold_o,
  output logic wdt_rst_pulse_o,
  output logic vec_load_o,
  output logic [rvec_pkg::PC_W-1:0] vec_addr_o,
  output logic irq_o
);
  import rvec_pkg::*;

  typedef struct packed {
    logic [2:0] pin_sync;
    logic pin_f;
    logic [2:0] ext_sync;
    logic ext_f;
    rvec_rst_t rs;
    logic [CNT_W-1:0] cnt;
    logic wdt_pulse;
    logic gie;
    logic gen_ext_en;
    logic tmr_en;
    logic cmp_en;
    logic wdt_en;
    logic [NSRC-1:0] flag;
    logic [5:0] evt;
    logic [5:0] evt_mask;
    rvec_irq_t is;
    logic [2:0] icnt;
    logic [1:0] win;
    logic post;
    logic [7:0] rdata;
    logic core_rst;
    logic core_hold;
    logic vec_load;
    logic [PC_W-1:0] vec_addr;
    logic irq;
  } rvec_state_t;

  localparam logic [NSRC-1:0][PC_W-1:0] VEC_TAB = {VEC_CMP, VEC_TMR, VEC_EXT};
  localparam logic [CNT_W-1:0] TOUT_LD = CNT_W'(TOUT_CYCLES - 1);
  localparam logic [CNT_W-1:0] POR_LD = CNT_W'(POR_CYCLES - 1);

  rvec_state_t q;
  rvec_state_t d;
  logic push;
  logic pop;
  logic [PC_W-1:0] stk_top;
  logic [NSRC-1:0] src_set;
  logic [NSRC-1:0] flag_clr;
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] pend;
  logic [1:0] win;
  logic [5:0] evt_set;
  logic [5:0] evt_clr;
  logic wr;

  rvec_stack #(
    .DEPTH(STACK_DEPTH),
    .W(PC_W)
  ) u_stack (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .push_i(push),
    .pop_i(pop),
    .pc_i(core_pc_i),
    .top_o(stk_top)
  );

  always_comb begin
    d = q;
    push = 1'b0;
    pop = 1'b0;
    flag_clr = '0;
    evt_set = '0;
    evt_clr = '0;
    wr = reg_we_i && (q.rs == RS_RUN);
    d.wdt_pulse = 1'b0;
    d.vec_load = 1'b0;
    d.rdata = 8'h00;

    // Pin filters: change taken once stages two and three agree
    d.pin_sync = {q.pin_sync[1:0], reset_pin_n_i};
    d.ext_sync = {q.ext_sync[1:0], ext_request_line_zero_n_i};
    if (q.pin_sync[1] == q.pin_sync[2]) begin
      d.pin_f = q.pin_sync[2];
    end
    if (q.ext_sync[1] == q.ext_sync[2]) begin
      d.ext_f = q.ext_sync[2];
    end

    // Source requests and enables
    src_set[0] = !q.ext_f;
    src_set[1] = timer_wrap_event_i;
    src_set[2] = comparator_event_i;
    src_en = {q.cmp_en, q.tmr_en, q.gen_ext_en};
    pend = q.flag & src_en;
    win = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win = 2'(i);
      end
    end

    // Reset sequencer
    case (q.rs)
      RS_POR: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - 1'b1;
        end else if (!q.pin_f) begin
          d.rs = RS_PIN;
        end else begin
          d.rs = RS_TOUT;
          d.cnt = TOUT_LD;
        end
      end
      RS_PIN: begin
        if (q.pin_f) begin
          d.rs = RS_TOUT;
          d.cnt = TOUT_LD;
        end
      end
      RS_WDT: begin
        d.rs = RS_TOUT;
        d.cnt = TOUT_LD;
      end
      RS_TOUT: begin
        if (!q.pin_f) begin
          d.rs = RS_PIN;
          evt_set[EVT_PIN_BIT] = 1'b1;
        end else if (q.cnt != '0) begin
          d.cnt = q.cnt - 1'b1;
        end else begin
          d.rs = RS_RUN;
          d.vec_load = 1'b1;
          d.vec_addr = VEC_RESET;
        end
      end
      RS_RUN: begin
        if (!q.pin_f) begin
          d.rs = RS_PIN;
          evt_set[EVT_PIN_BIT] = 1'b1;
        end else if (wdt_expire_i && q.wdt_en) begin
          d.rs = RS_WDT;
          d.wdt_pulse = 1'b1;
          evt_set[EVT_WDT_BIT] = 1'b1;
        end
      end
      default: begin
        d.rs = RS_POR;
        d.cnt = POR_LD;
      end
    endcase

    // Register writes
    if (wr) begin
      case (reg_addr_i)
        OFS_GLOBAL: begin
          d.gie = reg_wdata_i[GLOBAL_IE_BIT];
        end
        OFS_GEN_MASK: begin
          d.gen_ext_en = reg_wdata_i[GEN_EXT_BIT];
        end
        OFS_TMR_MASK: begin
          d.tmr_en = reg_wdata_i[TMR_WRAP_BIT];
        end
        OFS_TMR_FLAG: begin
          flag_clr[1] = reg_wdata_i[TMR_WRAP_BIT];
        end
        OFS_CTRL: begin
          d.cmp_en = reg_wdata_i[CTL_CMP_EN_BIT];
          d.wdt_en = reg_wdata_i[CTL_WDT_EN_BIT];
          flag_clr[2] = reg_wdata_i[CTL_CMP_FLAG_BIT];
        end
        OFS_EVT_STAT: begin
          evt_clr = reg_wdata_i[5:0];
        end
        OFS_EVT_MASK: begin
          d.evt_mask = reg_wdata_i[5:0];
        end
        default: begin
        end
      endcase
    end

    // Interrupt entry and return
    if (core_ready_i) begin
      d.post = 1'b0;
    end
    case (q.is)
      IS_IDLE: begin
        if (q.rs != RS_RUN) begin
          d.is = IS_IDLE;
        end else if (return_from_handler_i) begin
          d.is = IS_RET;
          d.icnt = RET_CYC - 3'h1;
        end else if (core_ready_i && q.gie && (pend != '0) && !q.post) begin
          d.is = IS_ENTRY;
          d.icnt = ENTRY_CYC - 3'h1;
          d.win = win;
          d.gie = 1'b0;
          push = 1'b1;
        end
      end
      IS_ENTRY: begin
        if (q.icnt != 3'h0) begin
          d.icnt = q.icnt - 3'h1;
        end else begin
          d.is = IS_IDLE;
          d.vec_load = 1'b1;
          d.vec_addr = VEC_TAB[q.win];
          flag_clr[q.win] = 1'b1;
        end
      end
      IS_RET: begin
        if (q.icnt != 3'h0) begin
          d.icnt = q.icnt - 3'h1;
        end else begin
          d.is = IS_IDLE;
          d.vec_load = 1'b1;
          d.vec_addr = stk_top;
          pop = 1'b1;
          d.gie = 1'b1;
          d.post = 1'b1;
        end
      end
      default: begin
        d.is = IS_IDLE;
      end
    endcase

    // Pending flags: a new request beats a write or vector clear
    d.flag = (q.flag & ~flag_clr) | src_set;
    evt_set[NSRC-1:0] = src_set;
    d.evt = (q.evt & ~evt_clr) | evt_set;

    // Any internal reset restores registers except event status
    if (d.rs != RS_RUN) begin
      d.gie = 1'b0;
      d.gen_ext_en = 1'b0;
      d.tmr_en = 1'b0;
      d.cmp_en = 1'b0;
      d.wdt_en = 1'b0;
      d.flag = '0;
      d.evt_mask = '0;
      d.is = IS_IDLE;
      d.icnt = 3'h0;
      d.post = 1'b0;
    end

    // Register reads, answered one cycle later
    if (reg_re_i) begin
      case (reg_addr_i)
        OFS_GLOBAL: begin
          d.rdata[GLOBAL_IE_BIT] = q.gie;
        end
        OFS_GEN_MASK: begin
          d.rdata[GEN_EXT_BIT] = q.gen_ext_en;
        end
        OFS_TMR_MASK: begin
          d.rdata[TMR_WRAP_BIT] = q.tmr_en;
        end
        OFS_TMR_FLAG: begin
          d.rdata[TMR_WRAP_BIT] = q.flag[1];
        end
        OFS_CTRL: begin
          d.rdata[CTL_CMP_EN_BIT] = q.cmp_en;
          d.rdata[CTL_WDT_EN_BIT] = q.wdt_en;
          d.rdata[CTL_CMP_FLAG_BIT] = q.flag[2];
        end
        OFS_EVT_STAT: begin
          d.rdata[5:0] = q.evt;
        end
        OFS_EVT_MASK: begin
          d.rdata[5:0] = q.evt_mask;
        end
        default: begin
          d.rdata = 8'h00;
        end
      endcase
    end

    d.core_rst = (d.rs != RS_RUN);
    d.core_hold = (d.is != IS_IDLE);
    d.irq = |(d.evt & d.evt_mask);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.pin_sync <= SYNC_RST;
      q.pin_f <= 1'b1;
      q.ext_sync <= SYNC_RST;
      q.ext_f <= 1'b1;
      q.rs <= RS_POR;
      q.cnt <= POR_LD;
      q.is <= IS_IDLE;
      q.evt <= EVT_RST;
      q.core_rst <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign core_rst_o = q.core_rst;
  assign core_hold_o = q.core_hold;
  assign wdt_rst_pulse_o = q.wdt_pulse;
  assign vec_load_o = q.vec_load;
  assign vec_addr_o = q.vec_addr;
  assign irq_o = q.irq;
endmodule

// ===== rvec_ctrl_chk.sv
// Checker for reset release, entry timing and register reads of rvec_ctrl.
// Assumes one clock domain and the async active-low power-on reset.
`timescale 1ns/1ps
module rvec_ctrl_chk #(
  parameter int unsigned TOUT_CYCLES = 20,
  parameter int unsigned POR_CYCLES = 10
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic reset_pin_n_i,
  input wire logic reg_re_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic core_rst_o,
  input wire logic core_hold_o,
  input wire logic wdt_rst_pulse_o,
  input wire logic vec_load_o,
  input wire logic [rvec_pkg::PC_W-1:0] vec_addr_o
);
  import rvec_pkg::*;
  int unsigned rc_q;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rc_q <= 0;
    end else begin
      rc_q <= core_rst_o ? rc_q + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_wdt; wdt_rst_pulse_o |=> !wdt_rst_pulse_o && core_rst_o; endproperty
  a_wdt: assert property (p_wdt) else $error("wdt pulse");
  property p_tout; $fell(core_rst_o) |-> rc_q >= TOUT_CYCLES; endproperty
  a_tout: assert property (p_tout) else $error("hold short");
  property p_fetch; $fell(core_rst_o) |-> vec_load_o && vec_addr_o == 9'h000; endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch 0");
  property p_entry; $rose(core_hold_o) |-> core_hold_o[*4] ##1 !core_hold_o; endproperty
  a_entry: assert property (p_entry) else $error("hold length");
  property p_load; vec_load_o |-> ($fell(core_hold_o) || $fell(core_rst_o)) ##1 !vec_load_o; endproperty
  a_load: assert property (p_load) else $error("load pulse");
  property p_rd; reg_rdata_o != 8'h00 |-> $past(reg_re_i); endproperty
  a_rd: assert property (p_rd) else $error("stray rdata");
  property p_res; $past(reg_re_i) && $past(reg_addr_i) == 6'h3B |-> !reg_rdata_o[7]; endproperty
  a_res: assert property (p_res) else $error("bit 7 set");
  property p_pin; !reset_pin_n_i [*6] |-> core_rst_o; endproperty
  a_pin: assert property (p_pin) else $error("pin no reset");
endmodule
bind rvec_ctrl rvec_ctrl_chk #(.TOUT_CYCLES(TOUT_CYCLES), .POR_CYCLES(POR_CYCLES)) u_rvec_ctrl_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reset_pin_n_i(reset_pin_n_i), .reg_re_i(reg_re_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .core_rst_o(core_rst_o), .core_hold_o(core_hold_o),
  .wdt_rst_pulse_o(wdt_rst_pulse_o), .vec_load_o(vec_load_o), .vec_addr_o(vec_addr_o));

// ===== rvec_pkg.sv
// Constants and types for reset sequencing and interrupt vectoring.
// Assumes a 20 MHz system clock and an 8-bit core with 9-bit program counter.
// Notes on behaviour
// - A source is taken only if its enable and the global enable are set.
// - Vectors: reset 0x000, external 0x001, timer wrap 0x002, comparator 0x003.
// - Lowest vector address wins; reset first, then the external request.
// - Reset causes: power applied, reset pin low, enabled watchdog expiry.
// - After the pin rises, the core stays halted for the startup delay.
// - At power-on the core is held for power-on period plus startup delay.
// - A pin still low after power-on extends the hold until release.
// - Watchdog expiry gives a one-cycle pulse; delay counts from its end.
// - Any reset restores registers, event status only at power-on; fetch then starts at address 0x000.
// - Taking an interrupt clears global enable; software or return sets it.
// - The source flag is cleared when its vector is loaded.
// - Writing one clears a clearable flag; zero bits stay unchanged.
// - General mask sits at 0x3B and timer mask at 0x39.
// - Bit 7 of the general mask always reads zero.
// - Entry takes 4 cycles at an instruction boundary, pushing the 9-bit PC.
// - Return takes 4 cycles popping PC; one instruction runs before next entry.
package rvec_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TOUT_MS = 16;
  localparam int unsigned POR_MS = 3;
  localparam int unsigned TOUT_CYC = TOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned POR_CYC = POR_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 20;
  localparam logic [2:0] ENTRY_CYC = 3'h4;
  localparam logic [2:0] RET_CYC = 3'h4;
  localparam int unsigned PC_W = 9;
  localparam int unsigned STACK_DEPTH = 3;
  localparam int unsigned NSRC = 3;
  localparam logic [5:0] OFS_GLOBAL = 6'h3F;
  localparam logic [5:0] OFS_GEN_MASK = 6'h3B;
  localparam logic [5:0] OFS_TMR_MASK = 6'h39;
  localparam logic [5:0] OFS_TMR_FLAG = 6'h38;
  localparam logic [5:0] OFS_CTRL = 6'h30;
  localparam logic [5:0] OFS_EVT_STAT = 6'h31;
  localparam logic [5:0] OFS_EVT_MASK = 6'h32;
  localparam int unsigned GLOBAL_IE_BIT = 7;
  localparam int unsigned GEN_EXT_BIT = 6;
  localparam int unsigned TMR_WRAP_BIT = 1;
  localparam int unsigned CTL_CMP_EN_BIT = 0;
  localparam int unsigned CTL_WDT_EN_BIT = 1;
  localparam int unsigned CTL_CMP_FLAG_BIT = 4;
  localparam int unsigned EVT_POR_BIT = 3;
  localparam int unsigned EVT_PIN_BIT = 4;
  localparam int unsigned EVT_WDT_BIT = 5;
  localparam logic [8:0] VEC_RESET = 9'h000;
  localparam logic [8:0] VEC_EXT = 9'h001;
  localparam logic [8:0] VEC_TMR = 9'h002;
  localparam logic [8:0] VEC_CMP = 9'h003;
  localparam logic [5:0] EVT_RST = 6'h08;
  localparam logic [2:0] SYNC_RST = 3'h7;
  typedef enum logic [2:0] {RS_POR, RS_PIN, RS_WDT, RS_TOUT, RS_RUN} rvec_rst_t;
  typedef enum logic [1:0] {IS_IDLE, IS_ENTRY, IS_RET} rvec_irq_t;
endpackage

// ===== rvec_stack.sv
// Return address stack, overwriting the oldest entry when full.
// Assumes push and pop never come in the same cycle.
`timescale 1ns/1ps
module rvec_stack #(
  parameter int unsigned DEPTH = rvec_pkg::STACK_DEPTH,
  parameter int unsigned W = rvec_pkg::PC_W
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [W-1:0] pc_i,
  output logic [W-1:0] top_o
);
  import rvec_pkg::*;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] lvl;
  } rvec_stk_t;
  rvec_stk_t q;
  rvec_stk_t d;
  always_comb begin
    d = q;
    if (push_i) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        d.lvl[i] = q.lvl[i-1];
      end
      d.lvl[0] = pc_i;
    end else if (pop_i) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.lvl[i] = q.lvl[i+1];
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign top_o = q.lvl[0];
endmodule

// ===== tb.sv
// Testbench: power-on, registers, vector order, watchdog and pin resets.
// Assumes short reset counts and the behavioural core model.
`timescale 1ns/1ps
module tb;
  import rvec_pkg::*;
  logic core_clk_i, rstn_i, pin, ext_n, tmr, cmp, wdt, we, re, slow, ready, ret, rst, hold, load, irq, wp;
  logic [5:0] addr;
  logic [7:0] wd, rdata;
  logic [8:0] pc, va;
  logic [8:0] q[$];
  int errors, checks, n, wpn;
  rvec_ctrl #(.TOUT_CYCLES(20), .POR_CYCLES(10)) u_rvec_ctrl (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .reset_pin_n_i(pin), .ext_request_line_zero_n_i(ext_n), .timer_wrap_event_i(tmr), .comparator_event_i(cmp),
    .wdt_expire_i(wdt), .core_ready_i(ready), .return_from_handler_i(ret), .core_pc_i(pc), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .core_rst_o(rst), .core_hold_o(hold),
    .wdt_rst_pulse_o(wp), .vec_load_o(load), .vec_addr_o(va), .irq_o(irq));
  rvec_core_model u_rvec_core_model (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .rst_i(rst), .hold_i(hold),
    .load_i(load), .addr_i(va), .slow_i(slow), .ready_o(ready), .ret_o(ret), .pc_o(pc));
  task automatic tk(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    tk(1);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    tk(1);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    tk(1);
    addr <= a;
    re <= 1'b1;
    tk(1);
    re <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {1'b0, rdata}, {1'b0, e});
  endtask
  task automatic wrel(output int c);
    for (c = 0; c < 10 && rst !== 1'b1; c++) begin
      tk(1);
      #1;
    end
    for (c = 0; c < 300 && rst !== 1'b0; c++) begin
      tk(1);
      #1;
    end
    if (c >= 300) begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic pulse(input int k);
    tk(1);
    case (k)
      0: begin
        tmr <= 1'b1;
      end
      1: begin
        cmp <= 1'b1;
      end
      default: begin
        wdt <= 1'b1;
      end
    endcase
    tk(1);
    {tmr, cmp, wdt} <= 3'h0;
  endtask
  always @(posedge core_clk_i) begin
    if (load && va != 9'h000 && va < 9'h004) begin
      q.push_back(va);
    end
    if (wp) begin
      wpn++;
    end
  end
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    {rstn_i, tmr, cmp, wdt, we, re, slow} = 7'h00;
    {pin, ext_n} = 2'h3;
    addr = 6'h00;
    wd = 8'h00;
    tk(6);
    rstn_i <= 1'b1;
    wrel(n);
    chk("por", 9'(n >= 30 && n <= 34), 9'h001);
    rd(6'h31, 8'h08);
    wr(6'h32, 8'h08);
    tk(2);
    #1;
    chk("irq on", {8'h00, irq}, 9'h001);
    wr(6'h31, 8'h08);
    tk(2);
    #1;
    chk("irq off", {8'h00, irq}, 9'h000);
    $display("test power_on done");
    rd(6'h3B, 8'h00);
    rd(6'h39, 8'h00);
    rd(6'h3F, 8'h00);
    wr(6'h3B, 8'hFF);
    rd(6'h3B, 8'h40);
    wr(6'h39, 8'hFF);
    rd(6'h39, 8'h02);
    rd(6'h20, 8'h00);
    wr(6'h30, 8'h01);
    slow <= 1'b1;
    ext_n <= 1'b0;
    pulse(0);
    pulse(1);
    tk(4);
    ext_n <= 1'b1;
    tk(8);
    chk("early", 9'(q.size()), 9'h000);
    wr(6'h38, 8'h00);
    rd(6'h38, 8'h02);
    rd(6'h30, 8'h11);
    wr(6'h3F, 8'h80);
    for (n = 0; n < 200 && q.size() < 3; n++) begin
      tk(1);
    end
    if (n >= 200) begin
      errors++;
      report_and_stop();
    end
    for (int i = 0; i < 3; i++) begin
      chk("vector", q[i], 9'(i + 1));
    end
    tk(20);
    rd(6'h38, 8'h00);
    rd(6'h30, 8'h01);
    rd(6'h3F, 8'h80);
    $display("test vectoring done");
    wr(6'h31, 8'h3F);
    wr(6'h30, 8'h02);
    pulse(2);
    wrel(n);
    chk("wdt", 9'(n >= 20 && n <= 28), 9'h001);
    rd(6'h31, 8'h20);
    rd(6'h30, 8'h00);
    pulse(2);
    tk(4);
    #1;
    chk("wdt off", {8'h00, rst}, 9'h000);
    chk("wdt pulses", 9'(wpn), 9'h001);
    $display("test watchdog done");
    wr(6'h31, 8'h3F);
    for (int p = 0; p < 2; p++) begin
      wr(6'h3B, 8'h40);
      tk(1);
      pin <= 1'b0;
      if (p == 1) begin
        rstn_i <= 1'b0;
      end
      tk(6);
      rstn_i <= 1'b1;
      tk(40);
      #1;
      chk("held", {8'h00, rst}, 9'h001);
      tk(1);
      pin <= 1'b1;
      wrel(n);
      chk("pin", 9'(n >= 20 && n <= 28), 9'h001);
      if (p == 0) begin
        rd(6'h31, 8'h10);
      end
      rd(6'h3B, 8'h00);
    end
    $display("test pin_reset done");
    report_and_stop();
  end
endmodule
